// >>> adcbs_seq.sv
// converter burst sequencer top
//
// Behaviour
// [RULE1] a burst wakes the converter, sums 1/4/8/16 samples, then returns to low power
// [RULE2] the burst runs on its own pacing, not tied to the core clock rate; here every step is clocked by core_clk_i, power-up wait in core cycles
// [RULE3] burst operation is active while the burst enable bit is one
// [RULE4] in burst, converter enable zero powers down after each burst, one stays on
// [RULE5] powered-down converter waits the power-up time; enabled converter converts at once
// [RULE6] software uses only post-tracking or dual-tracking modes during bursts
// [RULE7] burst: one start runs repeat count conversions; otherwise one start per conversion
// [RULE8] done flag sets only after repeat count conversions complete
// [RULE9] gain high byte is write-only at indirect address 0x04, never direct
// [RULE10] gain low nibble at indirect 0x07 in bits 7:4; bits 3:0 written zero
// [RULE11] input select routes one single-ended source: pins, temperature, supply or ground
// [RULE12] software sets used pins analog and makes the crossbar skip them
// [RULE13] samples of one group are summed into the result register pair
`timescale 1ns/100ps
`include "adcbs_cfg.svh"

module adcbs_seq #(
	parameter int SAMPLE_W = 12,
	parameter int RESULT_W = 16
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   burst_enable_i,
	input  wire logic                   converter_enable_i,
	input  wire logic [4:0]             power_up_time_i,
	input  wire logic [1:0]             repeat_sel_i,
	input  wire logic                   convert_start_i,
	input  wire logic                   done_clr_i,
	input  wire logic [5:0]             input_select_i,
	input  wire logic                   res_high_wr_i,
	input  wire logic                   res_low_wr_i,
	input  wire adcbs_pkg::adcbs_byte_t wdata_i,
	input  wire logic                   conv_done_i,
	input  wire logic [SAMPLE_W-1:0]    conv_data_i,
	output logic                        conv_req_o,
	output logic                        adc_power_o,
	output logic                        track_o,
	output logic                        conversion_done_flag_o,
	output logic [RESULT_W-1:0]         result_o,
	output logic [5:0]                  mux_sel_o,
	output logic [7:0]                  gain_upper_bits_o,
	output logic [3:0]                  gain_lower_bits_o
);
	import adcbs_pkg::*;

	localparam int          STEP_CYC = `ADCBS_PWRUP_STEP_CYC;
	localparam logic [8:0]  STEP_W9  = 9'(STEP_CYC);

	adcbs_state_e          state_r;
	adcbs_state_e          state_nxt;
	logic [8:0]            pwr_cnt_r;
	logic [4:0]            done_cnt_r;
	logic [4:0]            rpt_cnt;
	logic [RESULT_W-1:0]   acc_r;
	logic [RESULT_W-1:0]   acc_sum;
	logic                  start_ok;
	logic                  need_pwrup;
	logic                  last_conv;
	logic                  more_conv;
	logic                  enter_conv;
	logic                  pwr_done;
	logic                  req_r;
	logic                  flag_r;
	logic [5:0]            mux_r;

	// ----------------------------------------
	// decode of control bits
	// ----------------------------------------
	// repeat count from the two-bit select
	assign rpt_cnt = (repeat_sel_i == `ADCBS_RPT_1) ? 5'd1 :
	                 (repeat_sel_i == `ADCBS_RPT_4) ? 5'd4 :
	                 (repeat_sel_i == `ADCBS_RPT_8) ? 5'd8 : 5'd16;
	// [RULE3] burst active from the enable bit
	// non-burst starts are ignored while the converter is off
	assign start_ok   = convert_start_i && (burst_enable_i || converter_enable_i);
	// [RULE5] power-up only when idling powered down
	assign need_pwrup = burst_enable_i && !converter_enable_i;
	assign last_conv  = conv_done_i && ((done_cnt_r + 5'd1) == rpt_cnt);
	// [RULE7] burst chains conversions, non-burst waits for next start
	assign more_conv  = conv_done_i && !last_conv && burst_enable_i;
	assign pwr_done   = (pwr_cnt_r == 9'd0);
	// first sample of a group loads, later ones add
	assign acc_sum    = (done_cnt_r == 5'd0) ? RESULT_W'(conv_data_i) : acc_r + RESULT_W'(conv_data_i);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ADCBS_IDLE: begin
				if (start_ok) begin
					state_nxt = need_pwrup ? ADCBS_PWRUP : ADCBS_CONV;
				end
			end
			ADCBS_PWRUP: begin
				if (pwr_done) begin
					state_nxt = ADCBS_CONV;
				end
			end
			ADCBS_CONV: begin
				// [RULE1] back to idle power after the group
				if (conv_done_i && !more_conv) begin
					state_nxt = ADCBS_IDLE;
				end
			end
			default: begin
				state_nxt = ADCBS_IDLE;
			end
		endcase
	end

	// [RULE2] chaining paced by conv done alone, never by software
	// request pulses on every entry to a conversion
	assign enter_conv = ((state_r == ADCBS_IDLE) && start_ok && !need_pwrup) ||
	                    ((state_r == ADCBS_PWRUP) && pwr_done) ||
	                    ((state_r == ADCBS_CONV) && more_conv);

	// ----------------------------------------
	// state and request registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ADCBS_IDLE;
			req_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			req_r   <= enter_conv;
		end
	end

	// [RULE5] power-up wait counter
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwr_cnt_r <= 9'd0;
		end else if ((state_r == ADCBS_IDLE) && start_ok) begin
			pwr_cnt_r <= 9'((power_up_time_i + 9'd1) * STEP_W9 - 9'd1);
		end else if (!pwr_done) begin
			pwr_cnt_r <= pwr_cnt_r - 9'd1;
		end
	end

	// [RULE13] accumulate samples of the group
	// count survives idle so non-burst groups span several starts
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_cnt_r <= 5'd0;
			acc_r      <= '0;
		end else if (conv_done_i && (state_r == ADCBS_CONV)) begin
			done_cnt_r <= last_conv ? 5'd0 : done_cnt_r + 5'd1;
			acc_r      <= acc_sum;
		end
	end

	// [RULE8] flag and result after repeat count
	// a set in the cycle of a clear wins
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag_r   <= 1'b0;
			result_o <= '0;
		end else if (last_conv && (state_r == ADCBS_CONV)) begin
			flag_r   <= 1'b1;
			result_o <= acc_sum;
		end else if (done_clr_i) begin
			flag_r   <= 1'b0;
		end
	end

	// [RULE11] single source select, unused codes fall to ground
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mux_r <= `ADCBS_MUX_GND;
		end else begin
			mux_r <= (input_select_i > `ADCBS_MUX_GND) ? `ADCBS_MUX_GND : input_select_i;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// [RULE4] idle power follows converter enable
	assign adc_power_o            = converter_enable_i || (state_r != ADCBS_IDLE);
	assign track_o                = (state_r == ADCBS_CONV);
	assign conv_req_o             = req_r;
	assign conversion_done_flag_o = flag_r;
	assign mux_sel_o              = mux_r;

	adcbs_gain_regs u_gain (
		.core_clk_i        (core_clk_i),
		.rst_n_i           (rst_n_i),
		.res_high_wr_i     (res_high_wr_i),
		.res_low_wr_i      (res_low_wr_i),
		.wdata_i           (wdata_i),
		.gain_upper_bits_o (gain_upper_bits_o),
		.gain_lower_bits_o (gain_lower_bits_o)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_burst_low_power: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE1
		(state_r == ADCBS_IDLE && burst_enable_i && !converter_enable_i) |-> !adc_power_o)
		else $error("converter powered while idle in burst");
	a_burst_start_on: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE3
		(state_r == ADCBS_IDLE && convert_start_i && burst_enable_i) |=> (state_r != ADCBS_IDLE))
		else $error("burst start not taken");
	a_idle_power_sel: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE4
		converter_enable_i |-> adc_power_o)
		else $error("enabled converter not powered");
	a_pwrup_wait_len: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE5
		(state_r == ADCBS_IDLE && start_ok && need_pwrup && power_up_time_i == 5'd0)
		|=> (state_r == ADCBS_PWRUP) [*8] ##1 (state_r == ADCBS_CONV))
		else $error("power-up wait length wrong");
	a_direct_conv: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE5
		(state_r == ADCBS_IDLE && start_ok && !need_pwrup) |=> track_o && conv_req_o)
		else $error("enabled converter did not convert at once");
	a_burst_chain: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE7
		(track_o && conv_done_i && !last_conv && burst_enable_i) |=> conv_req_o)
		else $error("burst did not chain the next conversion");
	a_single_conv: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE7
		(track_o && conv_done_i && !burst_enable_i) |=> (state_r == ADCBS_IDLE))
		else $error("non-burst conversion chained");
	a_flag_after_count: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE8
		$rose(flag_r) |-> $past(last_conv))
		else $error("done flag set before repeat count");
	a_result_sum: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE13
		(track_o && last_conv) |=> (result_o == $past(acc_sum)) && flag_r)
		else $error("result not the group sum");
	a_mux_legal: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE11
		mux_sel_o <= `ADCBS_MUX_GND)
		else $error("illegal input select code");

	c_burst_pwrup: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		state_r == ADCBS_PWRUP ##[1:300] $rose(flag_r));
	c_burst_16: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(repeat_sel_i == `ADCBS_RPT_16) && burst_enable_i && $rose(flag_r));
	c_nonburst_4: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(repeat_sel_i == `ADCBS_RPT_4) && !burst_enable_i && $rose(flag_r));
	c_set_clear: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		done_clr_i && last_conv && track_o);

endmodule

// >>> adcbs_cfg.svh
// constants for the converter burst sequencer
`ifndef ADCBS_CFG_SVH
`define ADCBS_CFG_SVH

// ----------------------------------------
// indirect gain addresses
// ----------------------------------------
`define ADCBS_GAIN_HIGH_ADDR   8'h04
`define ADCBS_GAIN_LOW_ADDR    8'h07

// ----------------------------------------
// gain reset values and field positions
// ----------------------------------------
`define ADCBS_GAIN_HIGH_RST    8'hFC
`define ADCBS_GAIN_LOW_RST     4'h0
`define ADCBS_GAIN_LOW_MSB     7
`define ADCBS_GAIN_LOW_LSB     4

// ----------------------------------------
// repeat count encodings
// ----------------------------------------
`define ADCBS_RPT_1            2'h0
`define ADCBS_RPT_4            2'h1
`define ADCBS_RPT_8            2'h2
`define ADCBS_RPT_16           2'h3

// ----------------------------------------
// input select codes
// ----------------------------------------
`define ADCBS_MUX_LAST_PIN     6'h1F
`define ADCBS_MUX_TEMP         6'h20
`define ADCBS_MUX_VDD          6'h21
`define ADCBS_MUX_GND          6'h22

// ----------------------------------------
// timing: clock rate and power-up step
// ----------------------------------------
`define ADCBS_CLK_KHZ          40000
`define ADCBS_PWRUP_STEP_NS    200
`define ADCBS_PWRUP_STEP_CYC   ((`ADCBS_PWRUP_STEP_NS * `ADCBS_CLK_KHZ + 999999) / 1000000)

`endif

// >>> adcbs_pkg.sv
// types shared by the converter burst sequencer
package adcbs_pkg;

	// sequencer states, one-hot
	typedef enum logic [2:0] {
		ADCBS_IDLE  = 3'b001,
		ADCBS_PWRUP = 3'b010,
		ADCBS_CONV  = 3'b100
	} adcbs_state_e;

	typedef logic [7:0] adcbs_byte_t;

endpackage

// >>> adcbs_gain_regs.sv
// indirectly written gain registers
`timescale 1ns/100ps
`include "adcbs_cfg.svh"

module adcbs_gain_regs (
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 res_high_wr_i,
	input  wire logic                 res_low_wr_i,
	input  wire adcbs_pkg::adcbs_byte_t wdata_i,
	output logic [7:0]                gain_upper_bits_o,
	output logic [3:0]                gain_lower_bits_o
);
	import adcbs_pkg::*;

	logic [7:0] ind_addr_r;
	logic       hit_high;
	logic       hit_low;

	// ----------------------------------------
	// indirect address decode
	// ----------------------------------------
	// only the low-byte write stores data, so no direct path exists
	assign hit_high = res_low_wr_i && (ind_addr_r == `ADCBS_GAIN_HIGH_ADDR);
	assign hit_low  = res_low_wr_i && (ind_addr_r == `ADCBS_GAIN_LOW_ADDR);

	// high-byte write selects the indirect address
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ind_addr_r <= 8'h00;
		end else if (res_high_wr_i) begin
			ind_addr_r <= wdata_i;
		end
	end

	// [RULE9] indirect-only high gain
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gain_upper_bits_o <= `ADCBS_GAIN_HIGH_RST;
		end else if (hit_high) begin
			gain_upper_bits_o <= wdata_i;
		end
	end

	// [RULE10] low gain nibble, reserved bits dropped
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gain_lower_bits_o <= `ADCBS_GAIN_LOW_RST;
		end else if (hit_low) begin
			gain_lower_bits_o <= wdata_i[`ADCBS_GAIN_LOW_MSB:`ADCBS_GAIN_LOW_LSB];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_gain_high_ind: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE9
		(res_high_wr_i && !res_low_wr_i) |=> $stable(gain_upper_bits_o))
		else $error("gain high changed on a direct write");
	a_gain_low_take: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE10
		hit_low |=> (gain_lower_bits_o == $past(wdata_i[7:4])))
		else $error("gain low nibble not taken from bits 7 to 4");

endmodule

// >>> adc_burst_sequencer_bench.sv
// self-checking bench for the converter burst sequencer
`timescale 1ns/100ps
`include "adcbs_cfg.svh"

module adc_burst_sequencer_bench;
	import adcbs_pkg::*;

	logic        clk, rst_n, burst_en, conv_en, start, done_clr, hi_wr, lo_wr, conv_done;
	logic [4:0]  pwr;
	logic [1:0]  rsel;
	logic [5:0]  msel, mux;
	adcbs_byte_t wdata;
	logic [11:0] cdata;
	logic        req, pwr_o, trk, flag, flag_d;
	logic [15:0] res, sum_acc;
	logic [7:0]  gh, gv;
	logic [3:0]  gl;
	logic [31:0] lfsr_r;
	logic [15:0] exp_q[$];
	logic [5:0]  mcode[6] = '{6'h00, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h3F};
	logic [5:0]  mexp[6]  = '{6'h00, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h22};
	int          bad_count, tests_run, group_n, req_cnt, smp_cnt, i;

	adcbs_seq DUT (.core_clk_i(clk), .rst_n_i(rst_n), .burst_enable_i(burst_en), .converter_enable_i(conv_en),
		.power_up_time_i(pwr), .repeat_sel_i(rsel), .convert_start_i(start), .done_clr_i(done_clr),
		.input_select_i(msel), .res_high_wr_i(hi_wr), .res_low_wr_i(lo_wr), .wdata_i(wdata),
		.conv_done_i(conv_done), .conv_data_i(cdata), .conv_req_o(req), .adc_power_o(pwr_o), .track_o(trk),
		.conversion_done_flag_o(flag), .result_o(res), .mux_sel_o(mux), .gain_upper_bits_o(gh),
		.gain_lower_bits_o(gl));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function logic [31:0] lfsr_step(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
	endfunction

	function int rpt_n(input logic [1:0] r);
		return (r == `ADCBS_RPT_1) ? 1 : (r == `ADCBS_RPT_4) ? 4 : (r == `ADCBS_RPT_8) ? 8 : 16;
	endfunction

	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task end_sim;
		$display("checks=%0d mismatches=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one-cycle strobe: start when sel is 0, flag clear when sel is 1
	task pulse(input logic sel);
		@(posedge clk); {done_clr, start} <= sel ? 2'b10 : 2'b01;
		@(posedge clk); {done_clr, start} <= 2'b00;
	endtask

	// a wait that runs dry counts as a mismatch and closes the run
	task automatic wait_lvl(ref logic s, input logic v, input int n);
		int k;
		for (k = 0; k < n && s !== v; k++) begin
			@(posedge clk); #1;
		end
		if (s !== v) begin
			chk({15'h0, s}, {15'h0, v});
			end_sim();
		end
	endtask

	task gwr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk); wdata <= a; hi_wr <= 1'b1;
		@(posedge clk); hi_wr <= 1'b0; lo_wr <= 1'b1; wdata <= d;
		@(posedge clk); lo_wr <= 1'b0;
		@(posedge clk); #1;
	endtask

	// one burst: latency to tracking, then idle power state afterwards
	// no other tracking mode is ever driven during bursts
	task burst(input logic e, input logic [1:0] r, input logic [4:0] p);
		int k;
		int want;
		@(posedge clk); burst_en <= 1'b1; conv_en <= e; rsel <= r; pwr <= p;
		group_n = rpt_n(r);
		// first look is one cycle after the start edge; with power-up, tracking is first seen at the look equal to its whole wait
		want = e ? 1 : (int'(p) + 1) * `ADCBS_PWRUP_STEP_CYC;
		pulse(1'b0);
		for (k = 1; k < 400; k++) begin
			@(posedge clk); #1;
			if (trk === 1'b1) break;
		end
		chk(16'(k), 16'(want));
		if (k >= 400) end_sim();
		wait_lvl(flag, 1'b1, 3000);
		tick(2); #1;
		chk({15'h0, pwr_o}, {15'h0, e});
		pulse(1'b1); tick(1); #1;
		chk({15'h0, flag}, 16'h0);
	endtask

	// ----------------------------------------
	// clock and converter core stand-in
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// sums per group
	// random latency so back-to-back and stalled completions both occur
	initial begin
		forever begin
			@(posedge clk);
			if (req === 1'b1) begin
				lfsr_r = lfsr_step(lfsr_r);
				repeat (lfsr_r[1:0]) @(posedge clk);
				conv_done <= 1'b1; cdata <= lfsr_r[15:4];
				sum_acc = ((smp_cnt == 0) ? 16'h0 : sum_acc) + 16'(lfsr_r[15:4]);
				smp_cnt++;
				if (smp_cnt == group_n) begin
					exp_q.push_back(sum_acc);
					smp_cnt = 0;
				end
				@(posedge clk); conv_done <= 1'b0; cdata <= ~lfsr_r[15:4];
			end
		end
	end

	// ----------------------------------------
	// result watcher: oldest note per flag rise
	// ----------------------------------------
	always @(posedge clk) begin
		flag_d <= flag;
		if (req === 1'b1) req_cnt++;
		if (flag === 1'b1 && flag_d === 1'b0) begin
			chk(16'(exp_q.size()), 16'h1);
			if (exp_q.size() > 0) chk(res, exp_q.pop_front());
			chk(16'(req_cnt), 16'(group_n));
			req_cnt = 0;
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{burst_en, conv_en, start, done_clr, hi_wr, lo_wr, conv_done, flag_d} = '0;
		{pwr, rsel, msel, wdata, cdata} = '0;
		{bad_count, tests_run, group_n, req_cnt, smp_cnt} = '0;
		lfsr_r = 32'd65799;
		rst_n = 1'b0;
		repeat (7) @(posedge clk);
		#1;
		chk({10'h0, mux}, 16'h0022);
		@(posedge clk);
		rst_n <= 1'b1;
		tick(1); #1;
		chk({8'h0, gh}, 16'h00FC);
		chk({12'h0, gl}, 16'h0000);
		// select follows the input from the first edge after reset
		chk({10'h0, mux}, 16'h0000);
		chk({15'h0, flag}, 16'h0);
		burst(1'b1, `ADCBS_RPT_4, 5'h00);
		burst(1'b0, `ADCBS_RPT_1, 5'h00);
		burst(1'b1, `ADCBS_RPT_16, 5'h00);
		burst(1'b0, `ADCBS_RPT_8, 5'h1F);
		burst(1'b0, `ADCBS_RPT_16, lfsr_r[4:0]);
		@(posedge clk); burst_en <= 1'b0; conv_en <= 1'b1; rsel <= `ADCBS_RPT_4;
		group_n = 4;
		for (i = 0; i < 4; i++) begin
			chk({15'h0, flag}, 16'h0);
			pulse(1'b0);
			wait_lvl(trk, 1'b1, 20);
			wait_lvl(trk, 1'b0, 20);
			tick(1);
		end
		wait_lvl(flag, 1'b1, 20);
		pulse(1'b1);
		// start ignored with both enables low
		@(posedge clk); conv_en <= 1'b0;
		pulse(1'b0); tick(1); #1;
		chk({15'h0, trk}, 16'h0);
		// pin codes stand for pins set analog and skipped
		for (i = 0; i < 6; i++) begin
			@(posedge clk); msel <= mcode[i];
			tick(2); #1;
			chk({10'h0, mux}, {10'h0, mexp[i]});
		end
		gwr(`ADCBS_GAIN_HIGH_ADDR, 8'hAB);
		chk({8'h0, gh}, 16'h00AB);
		gv = {lfsr_r[7:4], 4'h0};
		gwr(`ADCBS_GAIN_LOW_ADDR, gv);
		chk({12'h0, gl}, {12'h0, gv[7:4]});
		gwr(8'h05, 8'h11);
		chk({gh, 4'h0, gl}, {8'hAB, 4'h0, gv[7:4]});
		tick(4);
		end_sim();
	end

endmodule
